// ### bench/pmbus_cfg_bank_tb_top.sv
// Self-checking bench for the configuration command bank
`timescale 1ns/1ps
module pmbus_cfg_bank_tb_top;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cal_lock_i = 1'b0;
   logic cmd_valid, cmd_write, cmd_pec_err, rsp_valid_o, busy_o;
   logic [7:0] cmd_code, comm_status_o;
   logic [15:0] cmd_wdata, rsp_data_o, setpoint_o, ov_limit_eff_o;
   logic [2:0] ov_retry_o, oc_retry_o;
   int err_count = 0;
   int tests_run = 0;
   always #25 core_clk_i = ~core_clk_i;
   pmbus_host_model host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid),
      .cmd_write_o(cmd_write), .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata),
      .cmd_pec_err_o(cmd_pec_err));
   pmbus_cfg_bank #(.RESTORE_CYCLES(20)) DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
      .cmd_wdata_i(cmd_wdata), .cmd_pec_err_i(cmd_pec_err), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .cal_lock_i(cal_lock_i), .busy_o(busy_o),
      .comm_status_o(comm_status_o), .setpoint_o(setpoint_o),
      .ov_limit_eff_o(ov_limit_eff_o), .ov_retry_o(ov_retry_o), .oc_retry_o(oc_retry_o));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
   begin
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // Command, answer and status, then status cleared
   task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d,
      input logic [15:0] ed, input logic [7:0] es);
   begin
      host.xfer(w, c, d, 1'b0);
      chk(rsp_data_o, ed);
      chk({8'h00, comm_status_o}, es);
      host.xfer(1'b1, 8'h7e, 16'h00e0, 1'b0);
   end
   endtask
   task automatic t_defaults();
   begin
      op(0, 8'h20, 0, 16'h0014, 0);
      op(1, 8'h20, 16'h0000, 0, 8'h80);
      op(0, 8'h21, 0, 16'hc000, 0);
      op(0, 8'h41, 0, 16'h00b8, 0);
      op(0, 8'h47, 0, 16'h00f8, 0);
      op(0, 8'h99, 0, 0, 8'h80);
      op(0, 8'h12, 0, 0, 8'h80);
      host.xfer(1, 8'h21, 16'h9800, 1'b1);
      chk({8'h00, comm_status_o}, 16'h0020);
      chk({15'h0, rsp_valid_o}, 16'h0001);
      chk(setpoint_o, 16'hc000);
      op(0, 8'h7e, 0, 16'h0020, 8'h20);
   end
   endtask
   task automatic t_ranges();
   begin
      op(1, 8'h21, 16'h97ff, 0, 8'h40);
      op(1, 8'h23, 16'h0401, 0, 8'h40);
      op(1, 8'h23, 16'hfc00, 0, 0);
      cal_lock_i = 1'b1;
      op(1, 8'h23, 16'h0000, 0, 8'h80);
      op(0, 8'h23, 0, 16'hfc00, 0);
      cal_lock_i = 1'b0;
      op(1, 8'h28, 16'h01f5, 0, 8'h40);
      op(1, 8'h28, 16'h01f4, 0, 0);
      op(1, 8'h26, 16'hc000, 0, 8'h40);
      op(1, 8'h26, 16'h9800, 0, 0);
      op(1, 8'h36, 16'h01a5, 0, 8'h40);
      op(1, 8'h35, 16'h01cd, 0, 8'h40);
      op(1, 8'h46, 16'h0103, 0, 8'h40);
      op(1, 8'h4a, 16'h0320, 0, 8'h40);
      op(1, 8'h40, 16'h9000, 0, 8'h40);
   end
   endtask
   task automatic t_actions();
   begin
      op(1, 8'h41, 16'h0010, 0, 8'h40);
      op(1, 8'h41, 16'h0000, 0, 0);
      op(0, 8'h41, 0, 16'h0080, 0);
      chk({13'h0, ov_retry_o}, 0);
      op(1, 8'h47, 16'h0007, 0, 0);
      op(0, 8'h47, 0, 16'h00c0, 0);
      chk({13'h0, oc_retry_o}, 0);
   end
   endtask
   task automatic t_cap_restore();
   begin
      op(1, 8'h21, 16'h9800, 0, 0);
      op(1, 8'h40, 16'hffd7, 0, 0);
      chk(ov_limit_eff_o, 16'hc800);
      host.xfer(1, 8'h12, 0, 1'b0);
      chk({15'h0, busy_o}, 16'h0001);
      host.xfer(1, 8'h21, 16'ha000, 1'b0);
      chk({8'h00, comm_status_o}, 16'h0080);
      // Host stays silent until busy drops; a stuck timer ends the run
      for (int i = 0; i < 100 && busy_o; i++)
      begin
         @(posedge core_clk_i);
         #1;
      end
      if (busy_o)
      begin
         err_count++;
         end_of_test();
      end
      op(1, 8'h7e, 16'h00e0, 0, 0);
      op(0, 8'h21, 0, 16'hc000, 0);
      op(0, 8'h41, 0, 16'h00b8, 0);
      op(0, 8'h47, 0, 16'h00f8, 0);
      chk(ov_limit_eff_o, 16'he000);
   end
   endtask
   task automatic end_of_test();
   begin
      if (err_count == 0 && tests_run > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   end
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk_i);
      #1 rst_b_i = 1'b1;
      t_defaults();
      t_ranges();
      t_actions();
      t_cap_restore();
      end_of_test();
   end
endmodule

// ### bench/pmbus_host_model.sv
// Host model issuing decoded PMBus transactions
`timescale 1ns/1ps
module pmbus_host_model (
   // Clock
   input wire logic core_clk_i,
   // Command port
   output logic cmd_valid_o,
   output logic cmd_write_o,
   output logic [7:0] cmd_code_o,
   output logic [15:0] cmd_wdata_o,
   output logic cmd_pec_err_o
);
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 16'h0000;
      cmd_pec_err_o = 1'b0;
   end
   // Answer is settled when this returns
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
   begin
      @(posedge core_clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_write_o = w;
      cmd_code_o = c;
      cmd_wdata_o = d;
      cmd_pec_err_o = p;
      @(posedge core_clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_pec_err_o = 1'b0;
      // Stale data must not look valid
      cmd_wdata_o = ~d;
   end
   endtask
endmodule

// ### rtl/ov_limit_cap.sv
// Effective overvoltage limit: user limit capped by set point headroom
`timescale 1ns/1ps
module ov_limit_cap (
   // Values
   input wire logic [15:0] setpoint_i,
   input wire logic [15:0] user_limit_i,
   // Result
   output logic [15:0] eff_limit_o
);
   logic [16:0] sum;
   logic [15:0] cap;

   always_comb
   begin
      sum = {1'b0, setpoint_i} + {1'b0, pmbus_cfg_pkg::OV_HEADROOM};
      // Wide sum so the ceiling still wins if the set point is high
      if (sum > {1'b0, pmbus_cfg_pkg::OV_MAX})
      begin
         cap = pmbus_cfg_pkg::OV_MAX;
      end
      else
      begin
         cap = sum[15:0];
      end
      eff_limit_o = (user_limit_i < cap) ? user_limit_i : cap; // see R10
   end
endmodule

// ### rtl/pmbus_cfg_bank.sv
// PMBus configuration command bank with range and cross checks
`timescale 1ns/1ps
module pmbus_cfg_bank #(
   parameter int RESTORE_CYCLES = pmbus_cfg_pkg::RESTORE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Decoded PMBus command port
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic cmd_pec_err_i,
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   // Device-type strap
   input wire logic cal_lock_i,
   // Status
   output logic busy_o,
   output logic [7:0] comm_status_o,
   // Settings to the power stage
   output logic [15:0] setpoint_o,
   output logic [15:0] ov_limit_eff_o,
   output logic [2:0] ov_retry_o,
   output logic [2:0] oc_retry_o
);
   // ----------------------------------------
   // Storage and handshake
   // ----------------------------------------
   logic [15:0] regs_q [pmbus_cfg_pkg::NUM_REGS];
   logic [7:0] cml_q;
   logic rsp_valid_q;
   logic [15:0] rsp_data_q;
   logic [15:0] eff_limit;
   logic [15:0] eff_limit_q;
   restore_if rif ();

   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   function automatic logic code_hit(input logic [7:0] code);
      unique case (code)
         pmbus_cfg_pkg::CMD_SETPOINT, pmbus_cfg_pkg::CMD_CAL,
         pmbus_cfg_pkg::CMD_MRG_HI, pmbus_cfg_pkg::CMD_MRG_LO,
         pmbus_cfg_pkg::CMD_DROOP, pmbus_cfg_pkg::CMD_TURN_ON,
         pmbus_cfg_pkg::CMD_TURN_OFF, pmbus_cfg_pkg::CMD_OV_LIM,
         pmbus_cfg_pkg::CMD_OV_ACT, pmbus_cfg_pkg::CMD_OC_LIM,
         pmbus_cfg_pkg::CMD_OC_ACT, pmbus_cfg_pkg::CMD_OC_WARN:
            code_hit = 1'b1;
         default:
            code_hit = 1'b0;
      endcase
   endfunction

   function automatic pmbus_cfg_pkg::reg_idx_e code_idx(input logic [7:0] code);
      unique case (code)
         pmbus_cfg_pkg::CMD_CAL: code_idx = pmbus_cfg_pkg::IDX_CAL;
         pmbus_cfg_pkg::CMD_MRG_HI: code_idx = pmbus_cfg_pkg::IDX_MRG_HI;
         pmbus_cfg_pkg::CMD_MRG_LO: code_idx = pmbus_cfg_pkg::IDX_MRG_LO;
         pmbus_cfg_pkg::CMD_DROOP: code_idx = pmbus_cfg_pkg::IDX_DROOP;
         pmbus_cfg_pkg::CMD_TURN_ON: code_idx = pmbus_cfg_pkg::IDX_TURN_ON;
         pmbus_cfg_pkg::CMD_TURN_OFF: code_idx = pmbus_cfg_pkg::IDX_TURN_OFF;
         pmbus_cfg_pkg::CMD_OV_LIM: code_idx = pmbus_cfg_pkg::IDX_OV_LIM;
         pmbus_cfg_pkg::CMD_OV_ACT: code_idx = pmbus_cfg_pkg::IDX_OV_ACT;
         pmbus_cfg_pkg::CMD_OC_LIM: code_idx = pmbus_cfg_pkg::IDX_OC_LIM;
         pmbus_cfg_pkg::CMD_OC_ACT: code_idx = pmbus_cfg_pkg::IDX_OC_ACT;
         pmbus_cfg_pkg::CMD_OC_WARN: code_idx = pmbus_cfg_pkg::IDX_OC_WARN;
         default: code_idx = pmbus_cfg_pkg::IDX_SETPOINT;
      endcase
   endfunction

   function automatic logic [15:0] def_value(input int idx);
      unique case (idx)
         int'(pmbus_cfg_pkg::IDX_CAL): def_value = pmbus_cfg_pkg::DEF_CAL;
         int'(pmbus_cfg_pkg::IDX_MRG_HI): def_value = pmbus_cfg_pkg::DEF_MRG_HI;
         int'(pmbus_cfg_pkg::IDX_MRG_LO): def_value = pmbus_cfg_pkg::DEF_MRG_LO;
         int'(pmbus_cfg_pkg::IDX_DROOP): def_value = pmbus_cfg_pkg::DEF_DROOP;
         int'(pmbus_cfg_pkg::IDX_TURN_ON): def_value = pmbus_cfg_pkg::DEF_TURN_ON;
         int'(pmbus_cfg_pkg::IDX_TURN_OFF): def_value = pmbus_cfg_pkg::DEF_TURN_OFF;
         int'(pmbus_cfg_pkg::IDX_OV_LIM): def_value = pmbus_cfg_pkg::DEF_OV_LIM;
         int'(pmbus_cfg_pkg::IDX_OV_ACT): def_value = pmbus_cfg_pkg::DEF_OV_ACT;
         int'(pmbus_cfg_pkg::IDX_OC_LIM): def_value = pmbus_cfg_pkg::DEF_OC_LIM;
         int'(pmbus_cfg_pkg::IDX_OC_ACT): def_value = pmbus_cfg_pkg::DEF_OC_ACT;
         int'(pmbus_cfg_pkg::IDX_OC_WARN): def_value = pmbus_cfg_pkg::DEF_OC_WARN;
         default: def_value = pmbus_cfg_pkg::DEF_SETPOINT;
      endcase
   endfunction

   function automatic logic retry_ok(input logic [15:0] d);
      retry_ok = (d[pmbus_cfg_pkg::RETRY_LSB +: 3] == pmbus_cfg_pkg::RETRY_NONE)
         || (d[pmbus_cfg_pkg::RETRY_LSB +: 3] == pmbus_cfg_pkg::RETRY_CONT);
   endfunction

   // ----------------------------------------
   // Request classification
   // ----------------------------------------
   logic take;
   logic hit;
   pmbus_cfg_pkg::reg_idx_e idx;
   logic data_ok;
   logic bad_cmd;
   logic do_write;
   logic do_restore;
   logic [15:0] merged;
   logic signed [15:0] sdata;

   assign take = cmd_valid_i && !cmd_pec_err_i;
   assign hit = code_hit(cmd_code_i);
   assign idx = code_idx(cmd_code_i);
   assign sdata = cmd_wdata_i;

   always_comb
   begin
      // Read-only bits are forced back, writable retry bits pass
      merged = cmd_wdata_i;
      if (idx == pmbus_cfg_pkg::IDX_OV_ACT)
      begin
         merged = {8'h00, pmbus_cfg_pkg::OV_RSP, cmd_wdata_i[5:3],
                   pmbus_cfg_pkg::DELAY_ZERO}; // see R11 see R13 see R20
      end
      else if (idx == pmbus_cfg_pkg::IDX_OC_ACT)
      begin
         merged = {8'h00, pmbus_cfg_pkg::OC_RSP, cmd_wdata_i[5:3],
                   pmbus_cfg_pkg::DELAY_ZERO}; // see R16 see R13 see R20
      end
   end

   always_comb
   begin
      data_ok = 1'b0;
      unique case (idx)
         pmbus_cfg_pkg::IDX_SETPOINT:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::VOUT_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::VOUT_MAX; // see R4
         pmbus_cfg_pkg::IDX_CAL:
            data_ok = sdata >= pmbus_cfg_pkg::CAL_MIN
               && sdata <= pmbus_cfg_pkg::CAL_MAX; // see R5
         pmbus_cfg_pkg::IDX_MRG_HI:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::VOUT_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::VOUT_MAX
               && cmd_wdata_i > regs_q[pmbus_cfg_pkg::IDX_MRG_LO]; // see R6
         pmbus_cfg_pkg::IDX_MRG_LO:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::VOUT_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::VOUT_MAX
               && cmd_wdata_i < regs_q[pmbus_cfg_pkg::IDX_MRG_HI]; // see R6
         pmbus_cfg_pkg::IDX_DROOP:
            data_ok = cmd_wdata_i <= pmbus_cfg_pkg::DROOP_MAX; // see R7
         pmbus_cfg_pkg::IDX_TURN_ON:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::VIN_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::VIN_MAX
               && cmd_wdata_i >= regs_q[pmbus_cfg_pkg::IDX_TURN_OFF]
                  + pmbus_cfg_pkg::VIN_GAP; // see R8
         pmbus_cfg_pkg::IDX_TURN_OFF:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::VIN_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::VIN_MAX
               && cmd_wdata_i + pmbus_cfg_pkg::VIN_GAP
                  <= regs_q[pmbus_cfg_pkg::IDX_TURN_ON]; // see R8
         pmbus_cfg_pkg::IDX_OV_LIM:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::OV_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::OV_MAX
               && cmd_wdata_i > regs_q[pmbus_cfg_pkg::IDX_SETPOINT]; // see R9
         pmbus_cfg_pkg::IDX_OV_ACT,
         pmbus_cfg_pkg::IDX_OC_ACT:
            data_ok = retry_ok(cmd_wdata_i); // see R12
         pmbus_cfg_pkg::IDX_OC_LIM:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::OC_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::OC_MAX
               && cmd_wdata_i > regs_q[pmbus_cfg_pkg::IDX_OC_WARN]; // see R15
         pmbus_cfg_pkg::IDX_OC_WARN:
            data_ok = cmd_wdata_i >= pmbus_cfg_pkg::WARN_MIN
               && cmd_wdata_i <= pmbus_cfg_pkg::WARN_MAX
               && cmd_wdata_i < regs_q[pmbus_cfg_pkg::IDX_OC_LIM]; // see R17
      endcase
   end

   always_comb
   begin
      bad_cmd = 1'b0;
      do_write = 1'b0;
      do_restore = 1'b0;
      if (take)
      begin
         if (rif.busy)
         begin
            // Host is expected to stay quiet; anything arriving is refused
            bad_cmd = 1'b1; // see R2
         end
         else if (cmd_code_i == pmbus_cfg_pkg::CMD_RESTORE)
         begin
            do_restore = cmd_write_i;
            bad_cmd = !cmd_write_i;
         end
         else if (cmd_code_i == pmbus_cfg_pkg::CMD_MODE)
         begin
            bad_cmd = cmd_write_i; // see R3
         end
         else if (cmd_code_i == pmbus_cfg_pkg::CMD_COMM_STAT)
         begin
            bad_cmd = 1'b0;
         end
         else if (!hit)
         begin
            bad_cmd = 1'b1;
         end
         else if (cmd_write_i && idx == pmbus_cfg_pkg::IDX_CAL && cal_lock_i)
         begin
            bad_cmd = 1'b1; // see R5
         end
         else
         begin
            do_write = cmd_write_i;
         end
      end
   end

   assign rif.start = do_restore;

   // ----------------------------------------
   // Parameter storage
   // ----------------------------------------
   generate
      for (genvar g = 0; g < pmbus_cfg_pkg::NUM_REGS; g++)
      begin : g_reg
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_b_i || rif.done)
            begin
               regs_q[g] <= def_value(g); // see R1 see R14 see R16
            end
            else if (do_write && data_ok && int'(idx) == g)
            begin
               regs_q[g] <= merged; // see R19
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Communication status, set wins over clear
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         cml_q <= 8'h00;
      end
      else
      begin
         for (int b = 0; b < 8; b++)
         begin
            if (take && cmd_write_i && !rif.busy
                && cmd_code_i == pmbus_cfg_pkg::CMD_COMM_STAT && cmd_wdata_i[b])
            begin
               cml_q[b] <= 1'b0;
            end
         end
         if (cmd_valid_i && cmd_pec_err_i)
         begin
            cml_q[pmbus_cfg_pkg::CML_PEC] <= 1'b1; // see R18
         end
         if (bad_cmd)
         begin
            cml_q[pmbus_cfg_pkg::CML_CMD] <= 1'b1; // see R18
         end
         if (do_write && !data_ok)
         begin
            cml_q[pmbus_cfg_pkg::CML_DATA] <= 1'b1; // see R19
         end
      end
   end

   // ----------------------------------------
   // Read answer
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 16'h0000;
      end
      else
      begin
         rsp_valid_q <= cmd_valid_i;
         if (!take || rif.busy || cmd_write_i)
         begin
            rsp_data_q <= 16'h0000;
         end
         else if (cmd_code_i == pmbus_cfg_pkg::CMD_MODE)
         begin
            rsp_data_q <= {8'h00, pmbus_cfg_pkg::MODE_VALUE}; // see R3
         end
         else if (cmd_code_i == pmbus_cfg_pkg::CMD_COMM_STAT)
         begin
            rsp_data_q <= {8'h00, cml_q};
         end
         else if (hit)
         begin
            rsp_data_q <= regs_q[idx];
         end
         else
         begin
            rsp_data_q <= 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // Helpers and outputs
   // ----------------------------------------
   restore_timer #(
      .RESTORE_CYCLES(RESTORE_CYCLES)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .rif(rif)
   );

   ov_limit_cap u_cap (
      .setpoint_i(regs_q[pmbus_cfg_pkg::IDX_SETPOINT]),
      .user_limit_i(regs_q[pmbus_cfg_pkg::IDX_OV_LIM]),
      .eff_limit_o(eff_limit)
   );

   // One cycle behind storage so the stage sees a settled limit
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         eff_limit_q <= pmbus_cfg_pkg::DEF_OV_LIM;
      end
      else
      begin
         eff_limit_q <= eff_limit; // see R10
      end
   end

   assign rsp_valid_o = rsp_valid_q;
   assign rsp_data_o = rsp_data_q;
   assign busy_o = rif.busy;
   assign comm_status_o = cml_q;
   assign setpoint_o = regs_q[pmbus_cfg_pkg::IDX_SETPOINT];
   assign ov_limit_eff_o = eff_limit_q;
   assign ov_retry_o = regs_q[pmbus_cfg_pkg::IDX_OV_ACT][pmbus_cfg_pkg::RETRY_LSB +: 3];
   assign oc_retry_o = regs_q[pmbus_cfg_pkg::IDX_OC_ACT][pmbus_cfg_pkg::RETRY_LSB +: 3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_restore_start: assert property ( // see R1
      do_restore |=> rif.busy [*3])
      else $error("restore did not start");
   chk_restore_load: assert property ( // see R1
      rif.done |=> regs_q[pmbus_cfg_pkg::IDX_SETPOINT] == pmbus_cfg_pkg::DEF_SETPOINT
         && regs_q[pmbus_cfg_pkg::IDX_OV_ACT] == pmbus_cfg_pkg::DEF_OV_ACT)
      else $error("defaults not reloaded");
   chk_mode_read: assert property ( // see R3
      take && !rif.busy && !cmd_write_i && cmd_code_i == pmbus_cfg_pkg::CMD_MODE
         |=> rsp_valid_o && rsp_data_o == {8'h00, pmbus_cfg_pkg::MODE_VALUE})
      else $error("format register wrong");
   chk_vout_range: assert property ( // see R4
      setpoint_o >= pmbus_cfg_pkg::VOUT_MIN && setpoint_o <= pmbus_cfg_pkg::VOUT_MAX)
      else $error("set point out of range");
   chk_margin_order: assert property ( // see R6
      regs_q[pmbus_cfg_pkg::IDX_MRG_LO] < regs_q[pmbus_cfg_pkg::IDX_MRG_HI])
      else $error("margin order broken");
   chk_vin_gap: assert property ( // see R8
      regs_q[pmbus_cfg_pkg::IDX_TURN_ON] >= regs_q[pmbus_cfg_pkg::IDX_TURN_OFF]
         + pmbus_cfg_pkg::VIN_GAP)
      else $error("input hysteresis broken");
   chk_ov_cap: assert property ( // see R10
      ##1 ov_limit_eff_o <= pmbus_cfg_pkg::OV_MAX
         && {1'b0, ov_limit_eff_o} <= {1'b0, $past(setpoint_o)}
            + {1'b0, pmbus_cfg_pkg::OV_HEADROOM})
      else $error("overvoltage cap exceeded");
   chk_action_fixed: assert property ( // see R11
      regs_q[pmbus_cfg_pkg::IDX_OV_ACT][7:6] == pmbus_cfg_pkg::OV_RSP
         && regs_q[pmbus_cfg_pkg::IDX_OC_ACT][7:6] == pmbus_cfg_pkg::OC_RSP
         && regs_q[pmbus_cfg_pkg::IDX_OC_ACT][2:0] == pmbus_cfg_pkg::DELAY_ZERO)
      else $error("fixed response bits changed");
   chk_reject_flag: assert property ( // see R19
      do_write && !data_ok |=> cml_q[pmbus_cfg_pkg::CML_DATA]
         && regs_q[$past(idx)] == $past(regs_q[idx]))
      else $error("bad write not rejected");
   chk_oc_order: assert property ( // see R17
      regs_q[pmbus_cfg_pkg::IDX_OC_WARN] < regs_q[pmbus_cfg_pkg::IDX_OC_LIM])
      else $error("warning not below fault");
endmodule

// ### rtl/pmbus_cfg_pkg.sv
// Constants and types for the PMBus configuration command bank
// Operation
// R1 - Restore-all reloads every operating parameter from stored defaults within 200 ms
// R2 - Host sends nothing further until the restore execution time has passed
// R3 - Output format register is read-only 0x14: linear mode, exponent -12
// R4 - Set point is unsigned mantissa, default 0xc000, accepted 9.5 V to 12 V
// R5 - Calibration offset accepts -0.25 V to +0.25 V; writes lockable by device type
// R6 - Margin levels accept 9.5 V to 12 V, low strictly below high
// R7 - Droop accepts 0 to 50.0 mV per ampere
// R8 - Input on/off accept 40 V to 46 V; on stays 2 V above off
// R9 - Overvoltage limit accepts 10.9 V to 15.99 V and must exceed set point
// R10 - Effective overvoltage limit capped at set point plus 3 V, at most 15.99 V
// R11 - Overvoltage response bits 7:6 read-only, fixed at 10
// R12 - Retry field bits 5:3 accepts only 000 or 111
// R13 - Delay bits 2:0 of each fault response read-only zero
// R14 - Overvoltage response defaults to 1011_1000
// R15 - Overcurrent limit accepts 26 A to 80.4 A, above warning limit
// R16 - Overcurrent response bits 7:6 fixed 11, retry writable, default 1111_1000
// R17 - Overcurrent warning accepts 20 A to 74 A, below fault limit
// R18 - Communication status holds bad command bit 7, bad data bit 6, PEC bit 5
// R19 - Out-of-range or cross-check-failing write rejected, old value kept, bad data flagged
// R20 - Writes to read-only bits leave them unchanged, writable bits update
package pmbus_cfg_pkg;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_RESTORE = 8'h12;
   localparam logic [7:0] CMD_MODE = 8'h20;
   localparam logic [7:0] CMD_SETPOINT = 8'h21;
   localparam logic [7:0] CMD_CAL = 8'h23;
   localparam logic [7:0] CMD_MRG_HI = 8'h25;
   localparam logic [7:0] CMD_MRG_LO = 8'h26;
   localparam logic [7:0] CMD_DROOP = 8'h28;
   localparam logic [7:0] CMD_TURN_ON = 8'h35;
   localparam logic [7:0] CMD_TURN_OFF = 8'h36;
   localparam logic [7:0] CMD_OV_LIM = 8'h40;
   localparam logic [7:0] CMD_OV_ACT = 8'h41;
   localparam logic [7:0] CMD_OC_LIM = 8'h46;
   localparam logic [7:0] CMD_OC_ACT = 8'h47;
   localparam logic [7:0] CMD_OC_WARN = 8'h4a;
   localparam logic [7:0] CMD_COMM_STAT = 8'h7e;
   // ----------------------------------------
   // Storage indices
   // ----------------------------------------
   typedef enum logic [3:0] {
      IDX_SETPOINT, IDX_CAL, IDX_MRG_HI, IDX_MRG_LO, IDX_DROOP, IDX_TURN_ON,
      IDX_TURN_OFF, IDX_OV_LIM, IDX_OV_ACT, IDX_OC_LIM, IDX_OC_ACT, IDX_OC_WARN
   } reg_idx_e;
   localparam int NUM_REGS = 12;
   // ----------------------------------------
   // Value scales: volts x4096, amps and input volts x10, droop x10
   // ----------------------------------------
   localparam logic [7:0] MODE_VALUE = 8'h14;
   localparam logic [15:0] VOUT_MIN = 16'h9800;
   localparam logic [15:0] VOUT_MAX = 16'hc000;
   localparam logic signed [15:0] CAL_MIN = 16'shfc00;
   localparam logic signed [15:0] CAL_MAX = 16'sh0400;
   localparam logic [15:0] DROOP_MAX = 16'h01f4;
   localparam logic [15:0] VIN_MIN = 16'h0190;
   localparam logic [15:0] VIN_MAX = 16'h01cc;
   localparam logic [15:0] VIN_GAP = 16'h0014;
   localparam logic [15:0] OV_MIN = 16'hae67;
   localparam logic [15:0] OV_MAX = 16'hffd7;
   localparam logic [15:0] OV_HEADROOM = 16'h3000;
   localparam logic [15:0] OC_MIN = 16'h0104;
   localparam logic [15:0] OC_MAX = 16'h0324;
   localparam logic [15:0] WARN_MIN = 16'h00c8;
   localparam logic [15:0] WARN_MAX = 16'h02e4;
   // ----------------------------------------
   // Fault response fields
   // ----------------------------------------
   localparam int RSP_LSB = 6;
   localparam int RETRY_LSB = 3;
   localparam logic [1:0] OV_RSP = 2'h2;
   localparam logic [1:0] OC_RSP = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_CONT = 3'h7;
   localparam logic [2:0] DELAY_ZERO = 3'h0;
   // ----------------------------------------
   // Defaults held in nonvolatile memory
   // ----------------------------------------
   localparam logic [15:0] DEF_SETPOINT = 16'hc000;
   localparam logic [15:0] DEF_CAL = 16'h0000;
   localparam logic [15:0] DEF_MRG_HI = 16'hc000;
   localparam logic [15:0] DEF_MRG_LO = 16'hb800;
   localparam logic [15:0] DEF_DROOP = 16'h0000;
   localparam logic [15:0] DEF_TURN_ON = 16'h01b8;
   localparam logic [15:0] DEF_TURN_OFF = 16'h01a4;
   localparam logic [15:0] DEF_OV_LIM = 16'he000;
   localparam logic [15:0] DEF_OV_ACT = 16'h00b8;
   localparam logic [15:0] DEF_OC_LIM = 16'h0320;
   localparam logic [15:0] DEF_OC_ACT = 16'h00f8;
   localparam logic [15:0] DEF_OC_WARN = 16'h02bc;
   // ----------------------------------------
   // Communication status bits
   // ----------------------------------------
   localparam int CML_CMD = 7;
   localparam int CML_DATA = 6;
   localparam int CML_PEC = 5;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int RESTORE_TIME_MS = 200;
   localparam int CLK_FREQ_KHZ = 20000;
   localparam int RESTORE_CYCLES = RESTORE_TIME_MS * CLK_FREQ_KHZ;
endpackage

// ### rtl/restore_if.sv
// Handshake between command bank and restore timer
`timescale 1ns/1ps
interface restore_if;
   logic start;
   logic busy;
   logic done;
   modport ctrl (output start, input busy, input done);
   modport timer (input start, output busy, output done);
endinterface

// ### rtl/restore_timer.sv
// Execution timer for the restore-all command
`timescale 1ns/1ps
module restore_timer #(
   parameter int RESTORE_CYCLES = pmbus_cfg_pkg::RESTORE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Handshake
   restore_if.timer rif
);
   logic [31:0] cnt_q;

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         cnt_q <= 32'h0000_0000;
         rif.busy <= 1'b0;
         rif.done <= 1'b0;
      end
      else
      begin
         rif.done <= 1'b0;
         if (rif.start && !rif.busy)
         begin
            rif.busy <= 1'b1;
            cnt_q <= 32'h0000_0001;
         end
         else if (rif.busy)
         begin
            // Busy spans the load edge, so no command lands only to be overwritten
            if (rif.done)
            begin
               rif.busy <= 1'b0;
            end
            else if (cnt_q >= 32'(RESTORE_CYCLES - 1))
            begin
               // Load then falls on the last cycle of the budget
               rif.done <= 1'b1;
            end
            else
            begin
               cnt_q <= cnt_q + 32'h0000_0001;
            end
         end
      end
   end
endmodule
